// ---- chgsp_alert_pulse.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "chgsp_params.svh"
module chgsp_alert_pulse
  import chgsp_pkg::*;
#(
  parameter int unsigned PULSE_CYC = `CHGSP_ALERT_CYC
)
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // event in, pin out
  input  wire logic trigger,
  output var  logic alert_oe
);

  typedef struct packed {
    chgsp_alert_e st;
    logic [15:0]  cnt;
    logic         oe;
  } chgsp_ap_s;

  chgsp_ap_s s_r;
  chgsp_ap_s s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    case (s_r.st)
      CHGSP_IDLE:
      begin
        if (trigger)
        begin
          s_nxt.st  = CHGSP_PULSE;
          s_nxt.cnt = 16'(PULSE_CYC - 1);
          s_nxt.oe  = 1'b1;
        end
      end
      default:
      begin
        if (s_r.cnt == 16'h0000)
        begin
          s_nxt.st = CHGSP_IDLE;
          s_nxt.oe = 1'b0;
        end
        else
        begin
          s_nxt.cnt = s_r.cnt - 16'h0001;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_r <= '{st: CHGSP_IDLE, cnt: 16'h0000, oe: 1'b0};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign alert_oe = s_r.oe;

  // pulse low time is exactly the programmed count
  logic [15:0] low_cnt_r;
  always_ff @(posedge sys_clk)
  begin
    if (rst || !alert_oe)
    begin
      low_cnt_r <= 16'h0000;
    end
    else
    begin
      low_cnt_r <= low_cnt_r + 16'h0001;
    end
  end

  a_alert_len_max: assert property (@(posedge sys_clk) disable iff (rst)
    alert_oe |-> low_cnt_r < 16'(PULSE_CYC))
    else $error("alert pulse too long");
  a_alert_len_min: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(alert_oe) |-> $past(low_cnt_r) == 16'(PULSE_CYC - 1))
    else $error("alert pulse wrong length");

endmodule
`default_nettype wire

// ---- chgsp_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module chgsp_host_model
(
  // device pin drives, high pulls low
  input  wire logic alert_pin_oe,
  input  wire logic charge_status_a_pin_oe,
  input  wire logic charge_status_b_pin_oe,
  input  wire logic power_good_pin_oe,
  input  wire logic charge_enable_pin_oe,
  // host drive of the enable pin
  input  wire logic host_ce_oe,
  input  wire logic host_ce_val,
  // resolved pin levels
  output var  logic alert_n,
  output var  logic stat_a_n,
  output var  logic stat_b_n,
  output var  logic power_good_n,
  output var  logic ce_level
);
  // pull-ups bring every released pin high
  assign alert_n      = alert_pin_oe ? 1'b0 : 1'b1;
  assign stat_a_n     = charge_status_a_pin_oe ? 1'b0 : 1'b1;
  assign stat_b_n     = charge_status_b_pin_oe ? 1'b0 : 1'b1;
  assign power_good_n = power_good_pin_oe ? 1'b0 : 1'b1;
  // host holds a firm level or releases to the pull-up, never floats
  assign ce_level = charge_enable_pin_oe ? 1'b0 : (host_ce_oe ? host_ce_val : 1'b1);
endmodule
`default_nettype wire

// ---- chgsp_params.svh ----
`ifndef CHGSP_PARAMS_SVH
`define CHGSP_PARAMS_SVH

// register offsets
`define CHGSP_OFF_CTRL      8'h00
`define CHGSP_OFF_FORCE     8'h01
`define CHGSP_OFF_CHARGE_CURRENT_SET_PIN      8'h02
`define CHGSP_OFF_STATUS    8'h03
`define CHGSP_OFF_IRQ_STAT  8'h04
`define CHGSP_OFF_IRQ_CLR   8'h05
`define CHGSP_OFF_IRQ_EN    8'h06
`define CHGSP_OFF_VWIN_LO   8'h07
`define CHGSP_OFF_VWIN_HI   8'h08

// control register fields
`define CHGSP_CTRL_STAT_DIS 0
`define CHGSP_CTRL_PG_DIS   1
`define CHGSP_CTRL_CE_DIS   2
`define CHGSP_CTRL_CHG_EN   3
`define CHGSP_CTRL_CHARGE_CURRENT_SET_PIN_PIN 4

// reset values
`define CHGSP_CTRL_RST      8'h18
`define CHGSP_FORCE_RST     8'h00
`define CHGSP_CHARGE_CURRENT_SET_PIN_RST      8'hff
`define CHGSP_VLO_RST       8'h40
`define CHGSP_VHI_RST       8'hc0

// alert pulse timing
`define CHGSP_ALERT_US      256
`define CHGSP_CLK_MHZ       40
`define CHGSP_ALERT_CYC     (`CHGSP_ALERT_US * `CHGSP_CLK_MHZ)

`endif

// ---- chgsp_pkg.sv ----
package chgsp_pkg;
  typedef logic [7:0] chgsp_byte_t;
  typedef logic [1:0] chgsp_chg_state_t;
  typedef enum {CHGSP_IDLE, CHGSP_PULSE} chgsp_alert_e;
endpackage

// ---- chgsp_status_pins.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "chgsp_params.svh"
module chgsp_status_pins
  import chgsp_pkg::*;
#(
  parameter int unsigned ALERT_CYC = `CHGSP_ALERT_CYC
)
(
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // register port
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output var  logic [7:0]       reg_rdata,
  // charger core status
  input  wire logic [7:0]       adapter_voltage,
  input  wire logic             thermistor_sense_input,
  input  wire logic [7:0]       charge_current_set_pin,
  input  wire chgsp_chg_state_t charge_state,
  input  wire logic             fault_event,
  // charge control out
  output var  logic             charge_allowed,
  output var  logic [7:0]       charge_current_limit,
  // open-drain pins, oe high pulls low
  output var  logic             alert_pin_oe,
  output var  logic             charge_status_a_pin_oe,
  output var  logic             charge_status_b_pin_oe,
  output var  logic             power_good_pin_oe,
  input  wire logic             charge_enable_pin_in,
  output var  logic             charge_enable_pin_oe,
  // interrupt
  output var  logic             irq
);

  typedef struct packed {
    chgsp_byte_t      ctrl;
    logic [3:0]       force_ind;
    chgsp_byte_t      charge_current_limit_field;
    chgsp_byte_t      vlo;
    chgsp_byte_t      vhi;
    logic [3:0]       irq_stat;
    logic [3:0]       irq_en;
    chgsp_byte_t      rdata;
    chgsp_chg_state_t last_state;
    logic             last_pg;
    logic             last_ts;
    logic             trig;
    logic             chg_ok;
    chgsp_byte_t      ilim;
    logic             stat_a;
    logic             stat_b;
    logic             pg;
    logic             ce_oe;
    logic             irq;
  } chgsp_sp_s;

  chgsp_sp_s s_r;
  chgsp_sp_s s_nxt;

  function automatic logic in_window(input chgsp_byte_t v, input chgsp_byte_t lo,
                                     input chgsp_byte_t hi);
    in_window = (v > lo) && (v < hi);
  endfunction

  function automatic chgsp_byte_t min8(input chgsp_byte_t a, input chgsp_byte_t b);
    min8 = (a < b) ? a : b;
  endfunction

  logic       stat_dis;
  logic       pg_dis;
  logic       ce_dis;
  logic       pg_now;
  logic [3:0] ev;

  always_comb
  begin
    stat_dis = s_r.ctrl[`CHGSP_CTRL_STAT_DIS];
    pg_dis   = s_r.ctrl[`CHGSP_CTRL_PG_DIS];
    ce_dis   = s_r.ctrl[`CHGSP_CTRL_CE_DIS];
    pg_now   = in_window(adapter_voltage, s_r.vlo, s_r.vhi);
    // events: state change, power good change, thermistor change, fault
    ev[0] = charge_state != s_r.last_state;
    ev[1] = pg_now != s_r.last_pg;
    ev[2] = thermistor_sense_input != s_r.last_ts;
    ev[3] = fault_event;

    s_nxt = s_r;
    s_nxt.last_state = charge_state;
    s_nxt.last_pg    = pg_now;
    s_nxt.last_ts    = thermistor_sense_input;
    s_nxt.trig       = |ev;
    s_nxt.rdata      = 8'h00;

    if (reg_wr)
    begin
      if (reg_addr == `CHGSP_OFF_CTRL)
      begin
        s_nxt.ctrl = reg_wdata & 8'h1f;
      end
      else if (reg_addr == `CHGSP_OFF_FORCE)
      begin
        s_nxt.force_ind = reg_wdata[3:0];
      end
      else if (reg_addr == `CHGSP_OFF_CHARGE_CURRENT_SET_PIN)
      begin
        s_nxt.charge_current_limit_field = reg_wdata;
      end
      else if (reg_addr == `CHGSP_OFF_IRQ_CLR)
      begin
        s_nxt.irq_stat = s_r.irq_stat & ~reg_wdata[3:0];
      end
      else if (reg_addr == `CHGSP_OFF_IRQ_EN)
      begin
        s_nxt.irq_en = reg_wdata[3:0];
      end
      else if (reg_addr == `CHGSP_OFF_VWIN_LO)
      begin
        s_nxt.vlo = reg_wdata;
      end
      else if (reg_addr == `CHGSP_OFF_VWIN_HI)
      begin
        s_nxt.vhi = reg_wdata;
      end
    end
    // set wins over clear
    s_nxt.irq_stat = s_nxt.irq_stat | ev;

    if (reg_rd)
    begin
      if (reg_addr == `CHGSP_OFF_CTRL)
      begin
        s_nxt.rdata = s_r.ctrl;
      end
      else if (reg_addr == `CHGSP_OFF_FORCE)
      begin
        s_nxt.rdata = {4'h0, s_r.force_ind};
      end
      else if (reg_addr == `CHGSP_OFF_CHARGE_CURRENT_SET_PIN)
      begin
        s_nxt.rdata = s_r.charge_current_limit_field;
      end
      else if (reg_addr == `CHGSP_OFF_STATUS)
      begin
        s_nxt.rdata = {2'b00, charge_enable_pin_in, thermistor_sense_input,
                       s_r.chg_ok, s_r.last_pg, s_r.last_state};
      end
      else if (reg_addr == `CHGSP_OFF_IRQ_STAT)
      begin
        s_nxt.rdata = {4'h0, s_r.irq_stat};
      end
      else if (reg_addr == `CHGSP_OFF_IRQ_EN)
      begin
        s_nxt.rdata = {4'h0, s_r.irq_en};
      end
      else if (reg_addr == `CHGSP_OFF_VWIN_LO)
      begin
        s_nxt.rdata = s_r.vlo;
      end
      else if (reg_addr == `CHGSP_OFF_VWIN_HI)
      begin
        s_nxt.rdata = s_r.vhi;
      end
    end

    s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_en);

    // status pins: core state or force bits
    if (stat_dis)
    begin
      s_nxt.stat_a = s_r.force_ind[0];
      s_nxt.stat_b = s_r.force_ind[1];
    end
    else
    begin
      s_nxt.stat_a = charge_state[0];
      s_nxt.stat_b = charge_state[1];
    end

    if (pg_dis)
    begin
      s_nxt.pg = s_r.force_ind[2];
    end
    else
    begin
      s_nxt.pg = pg_now;
    end

    s_nxt.ce_oe  = ce_dis & s_r.force_ind[3];
    // pin is assumed driven by the system when used as input
    s_nxt.chg_ok = s_r.ctrl[`CHGSP_CTRL_CHG_EN]
                   & (ce_dis | ~charge_enable_pin_in)
                   & thermistor_sense_input;

    if (s_r.ctrl[`CHGSP_CTRL_CHARGE_CURRENT_SET_PIN_PIN])
    begin
      s_nxt.ilim = min8(charge_current_set_pin, s_r.charge_current_limit_field);
    end
    else
    begin
      s_nxt.ilim = s_r.charge_current_limit_field;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_r <= '{ctrl: `CHGSP_CTRL_RST, force_ind: 4'h0, charge_current_limit_field: `CHGSP_CHARGE_CURRENT_SET_PIN_RST,
               vlo: `CHGSP_VLO_RST, vhi: `CHGSP_VHI_RST, irq_stat: 4'h0,
               irq_en: 4'h0, rdata: 8'h00, last_state: 2'b00, last_pg: 1'b0,
               last_ts: 1'b1, trig: 1'b0, chg_ok: 1'b0, ilim: 8'h00,
               stat_a: 1'b0, stat_b: 1'b0, pg: 1'b0, ce_oe: 1'b0, irq: 1'b0};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  chgsp_alert_pulse #(
    .PULSE_CYC (ALERT_CYC)
  ) u_alert (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .trigger  (s_r.trig),
    .alert_oe (alert_pin_oe)
  );

  assign reg_rdata              = s_r.rdata;
  assign charge_allowed         = s_r.chg_ok;
  assign charge_current_limit   = s_r.ilim;
  assign charge_status_a_pin_oe = s_r.stat_a;
  assign charge_status_b_pin_oe = s_r.stat_b;
  assign power_good_pin_oe      = s_r.pg;
  assign charge_enable_pin_oe   = s_r.ce_oe;
  assign irq                    = s_r.irq;

  a_stat_a_force: assert property (@(posedge sys_clk) disable iff (rst)
    $past(stat_dis) && !$past(rst) |-> charge_status_a_pin_oe == $past(s_r.force_ind[0]))
    else $error("status a not following force bit");
  a_stat_b_force: assert property (@(posedge sys_clk) disable iff (rst)
    $past(stat_dis) && !$past(rst) |-> charge_status_b_pin_oe == $past(s_r.force_ind[1]))
    else $error("status b not following force bit");
  a_stat_normal: assert property (@(posedge sys_clk) disable iff (rst)
    !$past(stat_dis) && !$past(rst) |-> charge_status_a_pin_oe == $past(charge_state[0]))
    else $error("status a not reporting charge state");
  a_pg_window: assert property (@(posedge sys_clk) disable iff (rst)
    !$past(pg_dis) && !$past(rst) |-> power_good_pin_oe == $past(pg_now))
    else $error("power good does not match window");
  a_pg_force: assert property (@(posedge sys_clk) disable iff (rst)
    $past(pg_dis) && !$past(rst) |-> power_good_pin_oe == $past(s_r.force_ind[2]))
    else $error("power good not following force bit");
  a_chg_qualify: assert property (@(posedge sys_clk) disable iff (rst)
    charge_allowed |-> $past(s_r.ctrl[`CHGSP_CTRL_CHG_EN])
                       && ($past(ce_dis) || !$past(charge_enable_pin_in)))
    else $error("charge allowed without qualification");
  a_ce_force: assert property (@(posedge sys_clk) disable iff (rst)
    charge_enable_pin_oe |-> $past(ce_dis) && $past(s_r.force_ind[3]))
    else $error("enable pin driven while not forced");
  a_ts_suspend: assert property (@(posedge sys_clk) disable iff (rst)
    !$past(thermistor_sense_input) |-> !charge_allowed)
    else $error("charging during temperature fault");
  a_ilim_min: assert property (@(posedge sys_clk) disable iff (rst)
    $past(s_r.ctrl[`CHGSP_CTRL_CHARGE_CURRENT_SET_PIN_PIN]) && !$past(rst)
    |-> charge_current_limit <= $past(charge_current_set_pin)
        && charge_current_limit <= $past(s_r.charge_current_limit_field))
    else $error("current limit not the minimum");
  a_ilim_reg: assert property (@(posedge sys_clk) disable iff (rst)
    !$past(s_r.ctrl[`CHGSP_CTRL_CHARGE_CURRENT_SET_PIN_PIN]) && !$past(rst)
    |-> charge_current_limit == $past(s_r.charge_current_limit_field))
    else $error("current limit ignores register");
  a_alert_start: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(s_r.trig) && !alert_pin_oe |=> alert_pin_oe)
    else $error("alert pulse not started");
  a_stat_b_normal: assert property (@(posedge sys_clk) disable iff (rst)
    !$past(stat_dis) && !$past(rst) |-> charge_status_b_pin_oe == $past(charge_state[1]))
    else $error("status b not reporting charge state");
  a_chg_grant: assert property (@(posedge sys_clk) disable iff (rst)
    !$past(rst) && $past(s_r.ctrl[`CHGSP_CTRL_CHG_EN]) && $past(thermistor_sense_input)
    && ($past(ce_dis) || !$past(charge_enable_pin_in)) |-> charge_allowed)
    else $error("charge refused although qualified");
  a_ce_follow: assert property (@(posedge sys_clk) disable iff (rst)
    $past(ce_dis) && !$past(rst) |-> charge_enable_pin_oe == $past(s_r.force_ind[3]))
    else $error("enable pin not following force bit");

endmodule
`default_nettype wire

// ---- chgsp_status_pins_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "chgsp_params.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin failures++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module chgsp_status_pins_tb
  import chgsp_pkg::*;
;
  localparam int ALERT_C = 16;
  logic             sys_clk = 1'b0;
  logic             rst = 1'b1;
  logic [7:0]       reg_addr = 8'h00;
  logic [7:0]       reg_wdata = 8'h00;
  logic             reg_wr = 1'b0;
  logic             reg_rd = 1'b0;
  logic [7:0]       reg_rdata;
  logic [7:0]       adapter_voltage = 8'h00;
  logic             ts = 1'b1;
  logic [7:0]       pin_lim = 8'h00;
  chgsp_chg_state_t charge_state = 2'b00;
  logic             fault_event = 1'b0;
  logic             charge_allowed;
  logic [7:0]       limit;
  logic             a_oe, sa_oe, sb_oe, pg_oe, ce_oe, irq;
  logic             host_ce_oe = 1'b1;
  logic             host_ce_val = 1'b0;
  logic             alert_n, stat_a_n, stat_b_n, power_good_n, ce_level;
  int               failures = 0;
  int               samples_checked = 0;

  chgsp_status_pins #(.ALERT_CYC(ALERT_C)) chgsp_status_pins_i (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .adapter_voltage(adapter_voltage), .thermistor_sense_input(ts),
    .charge_current_set_pin(pin_lim), .charge_state(charge_state),
    .fault_event(fault_event), .charge_allowed(charge_allowed),
    .charge_current_limit(limit), .alert_pin_oe(a_oe), .charge_status_a_pin_oe(sa_oe),
    .charge_status_b_pin_oe(sb_oe), .power_good_pin_oe(pg_oe),
    .charge_enable_pin_in(ce_level), .charge_enable_pin_oe(ce_oe), .irq(irq));

  chgsp_host_model chgsp_host_model_i (
    .alert_pin_oe(a_oe), .charge_status_a_pin_oe(sa_oe), .charge_status_b_pin_oe(sb_oe),
    .power_good_pin_oe(pg_oe), .charge_enable_pin_oe(ce_oe), .host_ce_oe(host_ce_oe),
    .host_ce_val(host_ce_val), .alert_n(alert_n), .stat_a_n(stat_a_n),
    .stat_b_n(stat_b_n), .power_good_n(power_good_n), .ce_level(ce_level));

  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic close_out;
    if (failures == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic settle;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  task automatic t_regs;
    logic [7:0] d;
    rd(`CHGSP_OFF_CTRL, d);    `CHK(d, `CHGSP_CTRL_RST)
    rd(`CHGSP_OFF_FORCE, d);   `CHK(d, `CHGSP_FORCE_RST)
    rd(`CHGSP_OFF_CHARGE_CURRENT_SET_PIN, d);    `CHK(d, `CHGSP_CHARGE_CURRENT_SET_PIN_RST)
    rd(`CHGSP_OFF_VWIN_LO, d); `CHK(d, `CHGSP_VLO_RST)
    rd(`CHGSP_OFF_VWIN_HI, d); `CHK(d, `CHGSP_VHI_RST)
    wr(8'h20, 8'h5a);
    rd(8'h20, d);              `CHK(d, 8'h00)
  endtask

  task automatic t_alert;
    logic [7:0] d;
    int         n;
    n = 0;
    while (alert_n !== 1'b1 && n < 100) begin @(posedge sys_clk); #1; n++; end
    wr(`CHGSP_OFF_IRQ_CLR, 8'hff);
    wr(`CHGSP_OFF_IRQ_EN, 8'h08);
    rd(`CHGSP_OFF_IRQ_STAT, d); `CHK(d, 8'h00)
    @(posedge sys_clk);
    fault_event <= 1'b1;
    @(posedge sys_clk);
    fault_event <= 1'b0;
    n = 0;
    while (alert_n !== 1'b0 && n < 10) begin @(posedge sys_clk); #1; n++; end
    `CHK(alert_n, 1'b0)
    `CHK(irq, 1'b1)
    n = 1;
    @(posedge sys_clk);
    #1;
    while (alert_n === 1'b0 && n < 100) begin n++; @(posedge sys_clk); #1; end
    `CHK(n, ALERT_C)
    rd(`CHGSP_OFF_IRQ_STAT, d); `CHK(d, 8'h08)
    wr(`CHGSP_OFF_IRQ_EN, 8'h00);
    settle();            `CHK(irq, 1'b0)
    wr(`CHGSP_OFF_IRQ_EN, 8'h08);
    settle();            `CHK(irq, 1'b1)
    wr(`CHGSP_OFF_IRQ_CLR, 8'h08);
    settle();            `CHK(irq, 1'b0)
  endtask

  task automatic t_stat;
    @(posedge sys_clk);
    charge_state <= 2'b01;
    settle(); `CHK({stat_a_n, stat_b_n}, 2'b01)
    @(posedge sys_clk);
    charge_state <= 2'b10;
    settle(); `CHK({stat_a_n, stat_b_n}, 2'b10)
    wr(`CHGSP_OFF_CTRL, 8'h19);
    wr(`CHGSP_OFF_FORCE, 8'h01);
    settle(); `CHK({stat_a_n, stat_b_n}, 2'b01)
    @(posedge sys_clk);
    charge_state <= 2'b01;
    wr(`CHGSP_OFF_FORCE, 8'h02);
    settle(); `CHK({stat_a_n, stat_b_n}, 2'b10)
    wr(`CHGSP_OFF_CTRL, 8'h18);
  endtask

  task automatic t_pg;
    adapter_voltage <= 8'h80;
    settle(); `CHK(power_good_n, 1'b0)
    @(posedge sys_clk);
    adapter_voltage <= 8'h40;
    settle(); `CHK(power_good_n, 1'b1)
    @(posedge sys_clk);
    adapter_voltage <= 8'h41;
    settle(); `CHK(power_good_n, 1'b0)
    @(posedge sys_clk);
    adapter_voltage <= 8'hc0;
    settle(); `CHK(power_good_n, 1'b1)
    wr(`CHGSP_OFF_CTRL, 8'h1a);
    wr(`CHGSP_OFF_FORCE, 8'h04);
    settle(); `CHK(power_good_n, 1'b0)
    @(posedge sys_clk);
    adapter_voltage <= 8'h80;
    wr(`CHGSP_OFF_FORCE, 8'h00);
    settle(); `CHK(power_good_n, 1'b1)
    wr(`CHGSP_OFF_CTRL, 8'h18);
  endtask

  task automatic t_charge;
    logic [7:0] d;
    host_ce_val <= 1'b0;
    settle(); `CHK(charge_allowed, 1'b1)
    @(posedge sys_clk);
    host_ce_val <= 1'b1;
    settle(); `CHK(charge_allowed, 1'b0)
    @(posedge sys_clk);
    host_ce_val <= 1'b0;
    ts <= 1'b0;
    settle(); `CHK(charge_allowed, 1'b0)
    @(posedge sys_clk);
    ts <= 1'b1;
    wr(`CHGSP_OFF_CTRL, 8'h10);
    settle(); `CHK(charge_allowed, 1'b0)
    @(posedge sys_clk);
    host_ce_val <= 1'b1;
    wr(`CHGSP_OFF_CTRL, 8'h1c);
    settle(); `CHK(charge_allowed, 1'b1)
    @(posedge sys_clk);
    host_ce_oe <= 1'b0;
    wr(`CHGSP_OFF_FORCE, 8'h08);
    settle(); `CHK(ce_level, 1'b0)
    `CHK(charge_allowed, 1'b1)
    wr(`CHGSP_OFF_FORCE, 8'h00);
    settle(); `CHK(ce_level, 1'b1)
    @(posedge sys_clk);
    host_ce_oe <= 1'b1;
    host_ce_val <= 1'b0;
    wr(`CHGSP_OFF_CTRL, 8'h18);
    // enable pin low, in range, charging, power good, state 01
    rd(`CHGSP_OFF_STATUS, d);   `CHK(d, 8'h1d)
    // state, power good and thermistor changes since the fault clear
    rd(`CHGSP_OFF_IRQ_STAT, d); `CHK(d, 8'h07)
  endtask

  task automatic t_limit;
    @(posedge sys_clk);
    pin_lim <= 8'h30;
    settle(); `CHK(limit, 8'h30)
    wr(`CHGSP_OFF_CHARGE_CURRENT_SET_PIN, 8'h20);
    settle(); `CHK(limit, 8'h20)
    @(posedge sys_clk);
    pin_lim <= 8'h10;
    settle(); `CHK(limit, 8'h10)
    wr(`CHGSP_OFF_CTRL, 8'h08);
    settle(); `CHK(limit, 8'h20)
  endtask

  initial
  begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    t_regs();
    t_alert();
    t_stat();
    t_pg();
    t_charge();
    t_limit();
    close_out();
  end

  initial
  begin
    #200000;
    failures++;
    close_out();
  end
endmodule
`default_nettype wire
